// ---- hw/cpu_regs_params.svh ----
// constants for the cpu register set: widths, field positions, reset values
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH
`define GPR_N 8
`define GPR_W 32
`define PC_W 24
`define CR_W 8
`define CCR_I 7
`define CCR_UI 6
`define CCR_H 5
`define CCR_U 4
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0
`define EXR_T 7
`define EXR_RSV_MASK 8'h78
`define EXR_IMASK 8'h07
`define FLAG_MASK 8'h2F
`define CCR_RST 8'h80
`define EXR_RST 8'h7F
`define PC_STEP 24'h000002
`define NORMAL_SPACE_MASK 24'h00FFFF
`define SP_IDX 3'h7
`define HB_BYTE 5'h03
`define HB_WORD 5'h0B
`define HB_LONG 5'h1B
`define MSB_BYTE 5'h07
`define MSB_WORD 5'h0F
`define MSB_LONG 5'h1F
`endif

// ---- hw/cpu_regs_pkg.sv ----
// types shared by the cpu register set
package cpu_regs_pkg;
`include "cpu_regs_params.svh"

  typedef logic [`GPR_W-1:0] word_t;
  typedef logic [`PC_W-1:0] pc_t;
  typedef logic [`CR_W-1:0] cr_t;

  typedef enum logic [2:0] {
    VIEW_FULL = 3'h0,
    VIEW_UPPER = 3'h1,
    VIEW_LOWER = 3'h2,
    VIEW_HIGH = 3'h3,
    VIEW_LOW = 3'h4
  } view_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_LOGIC = 3'h2,
    ALU_SHIFT = 3'h3,
    ALU_BIT = 3'h4
  } alu_e;

  typedef enum logic [2:0] {
    CTL_NONE = 3'h0,
    CTL_LOAD = 3'h1,
    CTL_AND = 3'h2,
    CTL_OR = 3'h3,
    CTL_XOR = 3'h4
  } ctl_e;

  typedef struct packed {
    word_t [7:0] gpr;
    pc_t pc;
    cr_t condition_flags;
    cr_t extended_control;
    logic mode_meta;
    logic mode_adv;
    word_t rd_a;
    word_t rd_b;
    pc_t fetch;
    pc_t ea;
    logic irq_take;
    logic br_taken;
  } state_s;
endpackage

// ---- hw/cpu_register_set_and_flags.sv ----
// cpu register set: general registers, program counter, control registers, flags
//
// Behaviour
// - eight alike 32-bit general registers, usable as address or data, 32/16/8-bit
// - each register splits into upper and lower 16-bit halves, sixteen in all
// - each lower half splits into high and low bytes, sixteen bytes in all
// - general register seven doubles as stack pointer, no separate register
// - 24-bit program counter; its bit zero reads as zero on fetch
// - normal mode reaches 64 kbytes, advanced mode 16 Mbytes
// - extended control bits six to three always read as one
// - extended control trace and mask bits have no effect on operation
// - mask bit set blocks all interrupts except nonmaskable, always accepted
// - every exception sequence start sets the condition mask bit
// - user bits six and four readable and writable by control instructions
// - half carry from bit 3, 11 or 27 on add and subtract kinds
// - negative flag takes the sign bit of the result
// - zero flag set for zero result, cleared otherwise
// - overflow flag set on arithmetic overflow, cleared otherwise
// - carry flag holds carry, borrow, shifted bit, or bit accumulator
// - branch conditions come from negative, zero, overflow and carry flags
// - reset loads pc from vector, clears trace, sets both mask fields
// - reset leaves other condition bits and general registers undefined
// - normal mode uses only the low 16 bits of an effective address
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_params.svh"

module cpu_register_set_and_flags
  import cpu_regs_pkg::*;
#(
  // register file shape
  parameter int GPR_COUNT = `GPR_N,
  parameter int GPR_WIDTH = `GPR_W,
  parameter int PC_WIDTH = `PC_W
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // general register reads
  input wire logic [2:0] RD_A_SEL,
  input wire view_e RD_A_VIEW,
  input wire logic [2:0] RD_B_SEL,
  input wire view_e RD_B_VIEW,
  output logic [31:0] RD_A_DATA,
  output logic [31:0] RD_B_DATA,
  output logic [31:0] STACK_PTR,
  // general register write
  input wire logic WR_EN,
  input wire logic [2:0] WR_SEL,
  input wire view_e WR_VIEW,
  input wire logic [31:0] WR_DATA,
  // program counter
  input wire logic PC_LOAD,
  input wire logic [23:0] PC_VALUE,
  input wire logic PC_ADVANCE,
  output logic [23:0] PC_OUT,
  output logic [23:0] FETCH_ADDR,
  // operating mode and effective address
  input wire logic MODE_ADV_PIN,
  input wire logic [31:0] EA_IN,
  output logic [23:0] EA_OUT,
  output logic ADV_MODE,
  // flag update from the datapath
  input wire logic [7:0] FLAG_WE,
  input wire alu_e ALU_KIND,
  input wire size_e ALU_SIZE,
  input wire logic [31:0] ALU_A,
  input wire logic [31:0] ALU_B,
  input wire logic [31:0] ALU_RES,
  input wire logic ALU_CBIT,
  // control register instructions
  input wire ctl_e CTL_OP,
  input wire logic CTL_TARGET_EXR,
  input wire logic [7:0] CTL_DATA,
  output logic [7:0] CCR_OUT,
  output logic [7:0] EXR_OUT,
  // exception handling
  input wire logic EXC_START,
  input wire logic RESET_EXC,
  input wire logic [23:0] VEC_ADDR,
  // interrupt acceptance
  input wire logic IRQ_REQ,
  input wire logic NMI_REQ,
  output logic IRQ_TAKE,
  // conditional branch
  input wire logic [3:0] BR_COND,
  output logic BR_TAKEN
);

  // ****************************************
  // parameter check
  // ****************************************

  // views, struct and ports are laid out for eight 32-bit words and a 24-bit counter
  if (GPR_COUNT != `GPR_N || GPR_WIDTH != `GPR_W || PC_WIDTH != `PC_W) begin : g_bad_shape
    $error("unsupported register set shape");
  end

  // ****************************************
  // view decoding
  // ****************************************

  // zero-extended read of one view of a register
  function automatic word_t view_read(input word_t w, input view_e v);
    word_t r;
    r = '0;
    unique case (v)
      VIEW_FULL: r = w;
      VIEW_UPPER: r = {16'h0000, w[31:16]};
      VIEW_LOWER: r = {16'h0000, w[15:0]};
      VIEW_HIGH: r = {24'h000000, w[15:8]};
      VIEW_LOW: r = {24'h000000, w[7:0]};
      default: r = w;
    endcase
    return r;
  endfunction

  // merge low-aligned data into one view, other bits kept
  function automatic word_t view_write(input word_t w, input word_t d, input view_e v);
    word_t r;
    r = w;
    unique case (v)
      VIEW_FULL: r = d;
      VIEW_UPPER: r[31:16] = d[15:0];
      VIEW_LOWER: r[15:0] = d[15:0];
      VIEW_HIGH: r[15:8] = d[7:0];
      VIEW_LOW: r[7:0] = d[7:0];
      default: r = w;
    endcase
    return r;
  endfunction

  // ****************************************
  // branch condition
  // ****************************************

  function automatic logic cond_met(input logic [3:0] c, input cr_t f);
    logic n;
    logic z;
    logic v;
    logic k;
    logic r;
    n = f[`CCR_N];
    z = f[`CCR_Z];
    v = f[`CCR_V];
    k = f[`CCR_C];
    r = 1'b0;
    unique case (c)
      4'h0: r = 1'b1;
      4'h1: r = 1'b0;
      4'h2: r = ~(k | z);
      4'h3: r = k | z;
      4'h4: r = ~k;
      4'h5: r = k;
      4'h6: r = ~z;
      4'h7: r = z;
      4'h8: r = ~v;
      4'h9: r = v;
      4'hA: r = ~n;
      4'hB: r = n;
      4'hC: r = ~(n ^ v);
      4'hD: r = n ^ v;
      4'hE: r = ~(z | (n ^ v));
      4'hF: r = z | (n ^ v);
    endcase
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************

  state_s q;
  state_s nx;

  logic [4:0] msb;
  logic [4:0] hb;
  word_t size_mask;
  logic a_s;
  logic b_s;
  logic r_s;
  logic half_c;
  logic carry_c;
  logic ovf;
  logic res_zero;
  cr_t flag_new;
  cr_t flag_en;
  cr_t ctl_src;
  cr_t ctl_val;
  pc_t space_mask;

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    nx = q;
    msb = `MSB_LONG;
    hb = `HB_LONG;
    size_mask = 32'hFFFFFFFF;
    unique case (ALU_SIZE)
      SZ_BYTE: begin
        msb = `MSB_BYTE;
        hb = `HB_BYTE;
        size_mask = 32'h000000FF;
      end
      SZ_WORD: begin
        msb = `MSB_WORD;
        hb = `HB_WORD;
        size_mask = 32'h0000FFFF;
      end
      default: begin
        msb = `MSB_LONG;
        hb = `HB_LONG;
        size_mask = 32'hFFFFFFFF;
      end
    endcase
    a_s = ALU_A[msb];
    b_s = ALU_B[msb];
    r_s = ALU_RES[msb];
    // carry into the next bit reveals carry or borrow out of hb
    half_c = ALU_A[hb + 5'h01] ^ ALU_B[hb + 5'h01] ^ ALU_RES[hb + 5'h01];
    res_zero = ((ALU_RES & size_mask) == 32'h00000000);
    carry_c = 1'b0;
    ovf = 1'b0;
    unique case (ALU_KIND)
      ALU_ADD: begin
        carry_c = (a_s & b_s) | ((a_s | b_s) & ~r_s);
        ovf = (a_s == b_s) & (r_s != a_s);
      end
      ALU_SUB: begin
        carry_c = (~a_s & b_s) | ((~a_s | b_s) & r_s);
        ovf = (a_s != b_s) & (r_s != a_s);
      end
      ALU_SHIFT: carry_c = ALU_CBIT;
      ALU_BIT: carry_c = ALU_CBIT;
      default: carry_c = q.condition_flags[`CCR_C];
    endcase
    flag_new = q.condition_flags;
    flag_new[`CCR_H] = ((ALU_KIND == ALU_ADD) || (ALU_KIND == ALU_SUB)) & half_c;
    flag_new[`CCR_N] = r_s;
    flag_new[`CCR_Z] = res_zero;
    flag_new[`CCR_V] = ovf;
    flag_new[`CCR_C] = carry_c;
    // bit accumulator instructions touch only the carry
    flag_en = FLAG_WE & `FLAG_MASK;
    if (ALU_KIND == ALU_BIT) begin
      flag_en = FLAG_WE & 8'h01;
    end
    nx.condition_flags = (q.condition_flags & ~flag_en) | (flag_new & flag_en);

    // control register load and logic ops, user bits included
    ctl_src = CTL_TARGET_EXR ? q.extended_control : nx.condition_flags;
    ctl_val = ctl_src;
    unique case (CTL_OP)
      CTL_LOAD: ctl_val = CTL_DATA;
      CTL_AND: ctl_val = ctl_src & CTL_DATA;
      CTL_OR: ctl_val = ctl_src | CTL_DATA;
      CTL_XOR: ctl_val = ctl_src ^ CTL_DATA;
      default: ctl_val = ctl_src;
    endcase
    if (CTL_OP != CTL_NONE) begin
      if (CTL_TARGET_EXR) begin
        nx.extended_control = ctl_val | `EXR_RSV_MASK;
      end else begin
        nx.condition_flags = ctl_val;
      end
    end

    // general register write
    if (WR_EN) begin
      nx.gpr[WR_SEL] = view_write(q.gpr[WR_SEL], WR_DATA, WR_VIEW);
    end

    // program counter
    if (PC_LOAD) begin
      nx.pc = PC_VALUE;
    end else if (PC_ADVANCE) begin
      nx.pc = q.pc + `PC_STEP;
    end

    // exception entry wins over any control write in the same cycle
    if (EXC_START) begin
      nx.condition_flags[`CCR_I] = 1'b1;
    end
    if (RESET_EXC) begin
      nx.pc = VEC_ADDR;
      nx.condition_flags[`CCR_I] = 1'b1;
      nx.extended_control[`EXR_T] = 1'b0;
      nx.extended_control = nx.extended_control | `EXR_IMASK;
    end

    // mode pin: first flop feeds only the second
    nx.mode_meta = MODE_ADV_PIN;
    nx.mode_adv = q.mode_meta;
    space_mask = q.mode_adv ? 24'hFFFFFF : `NORMAL_SPACE_MASK;
    nx.fetch = {nx.pc[23:1], 1'b0} & space_mask;
    // upper 8 of a 32-bit address lie beyond the 16-Mbyte pins
    nx.ea = q.mode_adv ? EA_IN[23:0] : {8'h00, EA_IN[15:0]};

    // reads sample the registers before this edge's write
    nx.rd_a = view_read(q.gpr[RD_A_SEL], RD_A_VIEW);
    nx.rd_b = view_read(q.gpr[RD_B_SEL], RD_B_VIEW);

    // extended control mask plays no part here
    nx.irq_take = NMI_REQ | (IRQ_REQ & ~q.condition_flags[`CCR_I]);
    nx.br_taken = cond_met(BR_COND, q.condition_flags);
  end

  // ****************************************
  // registers
  // ****************************************

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      // data cleared only so that nothing is unknown; software must not rely on it
      q <= '0;
      q.condition_flags <= `CCR_RST;
      q.extended_control <= `EXR_RST;
    end else begin
      q <= nx;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign RD_A_DATA = q.rd_a;
  assign RD_B_DATA = q.rd_b;
  assign STACK_PTR = q.gpr[`SP_IDX];
  assign PC_OUT = q.pc;
  assign FETCH_ADDR = q.fetch;
  assign EA_OUT = q.ea;
  assign ADV_MODE = q.mode_adv;
  assign CCR_OUT = q.condition_flags;
  assign EXR_OUT = q.extended_control;
  assign IRQ_TAKE = q.irq_take;
  assign BR_TAKEN = q.br_taken;

endmodule

`default_nettype wire

// ---- testbench/cpu_regs_properties.sv ----
// port assertions for the cpu register set
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_properties
  import cpu_regs_pkg::*;
(
  // watched ports
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WR_EN,
  input wire logic [2:0] WR_SEL,
  input wire view_e WR_VIEW,
  input wire logic [31:0] WR_DATA,
  input wire logic [31:0] STACK_PTR,
  input wire logic PC_LOAD,
  input wire logic PC_ADVANCE,
  input wire logic [23:0] PC_OUT,
  input wire logic ADV_MODE,
  input wire logic [23:0] EA_OUT,
  input wire logic EXC_START,
  input wire logic RESET_EXC,
  input wire logic [23:0] VEC_ADDR,
  input wire logic [7:0] CCR_OUT,
  input wire logic [7:0] EXR_OUT,
  input wire logic IRQ_REQ,
  input wire logic NMI_REQ,
  input wire logic IRQ_TAKE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_exr_ones: assert property (EXR_OUT[6:3] == 4'hF)
    else $error("reserved bits not one");
  a_pc_step: assert property (PC_ADVANCE && !PC_LOAD && !RESET_EXC |=>
    PC_OUT == $past(PC_OUT) + 24'h000002) else $error("pc step wrong");
  a_sp_alias: assert property (WR_EN && WR_SEL == 3'h7 && WR_VIEW == VIEW_FULL |=>
    STACK_PTR == $past(WR_DATA)) else $error("stack pointer not register seven");
  // two low samples so a mode change in flight is not judged
  a_ea_normal: assert property (!ADV_MODE [*2] |=> EA_OUT[23:16] == 8'h00)
    else $error("upper address bits used");
  a_exc_mask: assert property (EXC_START |=> CCR_OUT[7])
    else $error("mask not set");
  a_rst_exc: assert property (RESET_EXC |=> PC_OUT == $past(VEC_ADDR) &&
    EXR_OUT == 8'h7F && CCR_OUT[7]) else $error("reset sequence wrong");
  a_nmi_take: assert property (NMI_REQ |=> IRQ_TAKE)
    else $error("nmi refused");
  a_irq_mask: assert property (IRQ_REQ && !NMI_REQ && CCR_OUT[7] |=> !IRQ_TAKE)
    else $error("masked request taken");
  a_irq_open: assert property (IRQ_REQ && !CCR_OUT[7] |=> IRQ_TAKE)
    else $error("open request refused");
  c_rst_exc: cover property (RESET_EXC);
  c_nmi_masked: cover property (NMI_REQ && CCR_OUT[7]);
  c_sp_write: cover property (WR_EN && WR_SEL == 3'h7);
endmodule
bind cpu_register_set_and_flags cpu_regs_properties i_cpu_regs_properties (
  .CLK(CLK), .RST_B(RST_B), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .WR_VIEW(WR_VIEW),
  .WR_DATA(WR_DATA), .STACK_PTR(STACK_PTR), .PC_LOAD(PC_LOAD), .PC_ADVANCE(PC_ADVANCE),
  .PC_OUT(PC_OUT), .ADV_MODE(ADV_MODE), .EA_OUT(EA_OUT), .EXC_START(EXC_START),
  .RESET_EXC(RESET_EXC), .VEC_ADDR(VEC_ADDR), .CCR_OUT(CCR_OUT), .EXR_OUT(EXR_OUT),
  .IRQ_REQ(IRQ_REQ), .NMI_REQ(NMI_REQ), .IRQ_TAKE(IRQ_TAKE));
`default_nettype wire

// ---- testbench/alu_model.sv ----
// datapath result source: add, subtract, else passes operand b
`timescale 1ns/1ps
`default_nettype none
module alu_model
  import cpu_regs_pkg::*;
(
  // operation and operands
  input wire alu_e kind,
  input wire size_e sz,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [31:0] res
);
  logic [31:0] raw;
  // result cut to the operand size, as the real datapath hands it over
  always_comb begin
    raw = (kind == ALU_ADD) ? a + b : (kind == ALU_SUB) ? a - b : b;
    res = raw & ((sz == SZ_BYTE) ? 32'hFF : (sz == SZ_WORD) ? 32'hFFFF : 32'hFFFFFFFF);
  end
endmodule
`default_nettype wire

// ---- testbench/cpu_register_set_and_flags_bench.sv ----
// self-checking bench for the cpu register set
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_and_flags_bench
  import cpu_regs_pkg::*;
;
  typedef struct packed {
    alu_e k;
    size_e s;
    logic [31:0] a;
    logic [31:0] b;
    logic c;
    logic [7:0] f;
  } row_s;
  logic clk = 1'h0, rst_b = 1'h0, wr_en = 1'h0, pc_load = 1'h0, pc_adv = 1'h0;
  logic mode = 1'h0, cbit = 1'h0, exc = 1'h0, rexc = 1'h0, irq = 1'h0, nmi = 1'h0;
  logic tgt = 1'h0, adv, take, br;
  logic [2:0] sa = 3'h0, sb = 3'h0, ws = 3'h0;
  logic [3:0] bc = 4'h0;
  logic [7:0] fwe = 8'h00, cd = 8'h00, condition_flags, extended_control;
  logic [23:0] pcv = 24'h000000, vec = 24'h000000, pco, fa, eao;
  logic [31:0] wd = 32'h0, ea = 32'h0, a = 32'h0, b = 32'h0, res, rda, rdb, sp;
  view_e va = VIEW_FULL, vb = VIEW_FULL, wv = VIEW_FULL;
  alu_e kind = ALU_ADD;
  size_e sz = SZ_BYTE;
  ctl_e op = CTL_NONE;
  int fail_count = 0, checked = 0;
  // kind, size, operands, shifted bit, expected flag bits
  row_s rows [8] = '{'{ALU_ADD, SZ_BYTE, 32'h0F, 32'h01, 1'h0, 8'h20},
    '{ALU_ADD, SZ_BYTE, 32'hFF, 32'h01, 1'h0, 8'h25},
    '{ALU_ADD, SZ_WORD, 32'h7FFF, 32'h01, 1'h0, 8'h2A},
    '{ALU_SUB, SZ_LONG, 32'h00, 32'h01, 1'h0, 8'h29},
    '{ALU_ADD, SZ_LONG, 32'h01, 32'h01, 1'h0, 8'h00},
    '{ALU_LOGIC, SZ_BYTE, 32'h00, 32'h80, 1'h0, 8'h08},
    '{ALU_SHIFT, SZ_WORD, 32'h00, 32'h00, 1'h1, 8'h05},
    '{ALU_BIT, SZ_BYTE, 32'h00, 32'h00, 1'h0, 8'h04}};
  ctl_e cop [4] = '{CTL_LOAD, CTL_XOR, CTL_OR, CTL_AND};
  logic [7:0] cdat [4] = '{8'h50, 8'h10, 8'h01, 8'hF0};
  logic [7:0] cexp [4] = '{8'h50, 8'h40, 8'h41, 8'h40};
  logic [31:0] gv [5] = '{32'hCCDDBBAA, 32'hCCDD, 32'hBBAA, 32'hBB, 32'hAA};
  logic [15:0] bexp = 16'h9599;

  cpu_register_set_and_flags i_cpu_register_set_and_flags (
    .CLK(clk), .RST_B(rst_b), .RD_A_SEL(sa), .RD_A_VIEW(va), .RD_B_SEL(sb),
    .RD_B_VIEW(vb), .RD_A_DATA(rda), .RD_B_DATA(rdb), .STACK_PTR(sp), .WR_EN(wr_en),
    .WR_SEL(ws), .WR_VIEW(wv), .WR_DATA(wd), .PC_LOAD(pc_load), .PC_VALUE(pcv),
    .PC_ADVANCE(pc_adv), .PC_OUT(pco), .FETCH_ADDR(fa), .MODE_ADV_PIN(mode),
    .EA_IN(ea), .EA_OUT(eao), .ADV_MODE(adv), .FLAG_WE(fwe), .ALU_KIND(kind),
    .ALU_SIZE(sz), .ALU_A(a), .ALU_B(b), .ALU_RES(res), .ALU_CBIT(cbit), .CTL_OP(op),
    .CTL_TARGET_EXR(tgt), .CTL_DATA(cd), .CCR_OUT(condition_flags), .EXR_OUT(extended_control),
    .EXC_START(exc), .RESET_EXC(rexc), .VEC_ADDR(vec), .IRQ_REQ(irq), .NMI_REQ(nmi),
    .IRQ_TAKE(take), .BR_COND(bc), .BR_TAKEN(br));
  alu_model i_alu_model (.kind(kind), .sz(sz), .a(a), .b(b), .res(res));

  always #12.5 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  // leaves the strobe up so back-to-back writes never toggle it in one step
  task automatic wr(input logic [2:0] s, input view_e v, input logic [31:0] d);
    ws = s;
    wv = v;
    wd = d;
    wr_en = 1'h1;
    cyc;
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // about 75 cycles of tests; a hang is cut at 2000 cycles, over twenty-five times that
  initial begin
    #(25 * 2000);
    fail_count++;
    give_verdict;
  end

  initial begin
    cyc(20);
    chk("ccr mask", condition_flags[7], 1'h1);
    chk("exr", extended_control, 8'h7F);
    rst_b = 1'h1;
    fwe = 8'h2F;
    foreach (rows[i]) begin
      kind = rows[i].k;
      sz = rows[i].s;
      a = rows[i].a;
      b = rows[i].b;
      cbit = rows[i].c;
      cyc;
      chk("flags", condition_flags & 8'h2F, rows[i].f);
    end
    fwe = 8'h00;
    for (int i = 0; i < 16; i++) begin
      bc = 4'(i);
      cyc;
      chk("branch", br, bexp[i]);
    end
    $display("flag and branch rows done");
    wr(3'h7, VIEW_FULL, 32'hFFFC);
    chk("sp", sp, 32'hFFFC);
    wr(3'h3, VIEW_FULL, 32'h12345678);
    wr(3'h3, VIEW_UPPER, 32'hCCDD);
    // upper data bits of a half write must not reach the upper half
    wr(3'h3, VIEW_LOWER, 32'hFFFF1111);
    wr(3'h3, VIEW_LOW, 32'hAA);
    wr(3'h3, VIEW_HIGH, 32'hBB);
    wr_en = 1'h0;
    sa = 3'h3;
    sb = 3'h3;
    for (int i = 0; i < 5; i++) begin
      va = view_e'(i);
      cyc;
      chk("read a", rda, gv[i]);
    end
    chk("read b", rdb, 32'hCCDDBBAA);
    $display("register views done");
    mode = 1'h1;
    pcv = 24'h123457;
    pc_load = 1'h1;
    cyc(3);
    pc_load = 1'h0;
    chk("adv", adv, 1'h1);
    chk("pc", pco, 24'h123457);
    chk("fetch", fa, 24'h123456);
    ea = 32'h12345678;
    pc_adv = 1'h1;
    cyc;
    chk("pc", pco, 24'h123459);
    chk("ea", eao, 24'h345678);
    mode = 1'h0;
    cyc(3);
    pc_adv = 1'h0;
    chk("fetch", fa, 24'h00345E);
    chk("ea", eao, 24'h005678);
    $display("pc and address done");
    foreach (cop[i]) begin
      op = cop[i];
      cd = cdat[i];
      cyc;
      chk("ccr", condition_flags, cexp[i]);
    end
    op = CTL_LOAD;
    tgt = 1'h1;
    cd = 8'h87;
    cyc;
    op = CTL_NONE;
    chk("exr", extended_control, 8'hFF);
    irq = 1'h1;
    cyc;
    chk("take", take, 1'h1);
    // exception entry and a mask-clearing control op in one cycle: the set wins
    exc = 1'h1;
    op = CTL_AND;
    tgt = 1'h0;
    cd = 8'h7F;
    cyc;
    exc = 1'h0;
    op = CTL_NONE;
    chk("ccr", condition_flags, 8'hC0);
    cyc;
    chk("take", take, 1'h0);
    nmi = 1'h1;
    cyc;
    chk("take", take, 1'h1);
    vec = 24'h000200;
    rexc = 1'h1;
    cyc;
    rexc = 1'h0;
    chk("pc", pco, 24'h000200);
    chk("exr", extended_control, 8'h7F);
    op = CTL_OR;
    tgt = 1'h1;
    cd = 8'h80;
    cyc;
    op = CTL_NONE;
    chk("exr trace", extended_control, 8'hFF);
    rst_b = 1'h0;
    cyc;
    chk("exr", extended_control, 8'h7F);
    chk("ccr mask", condition_flags[7], 1'h1);
    rst_b = 1'h1;
    cyc;
    chk("take", take, 1'h1);
    chk("exr", extended_control, 8'h7F);
    $display("control and exceptions done");
    give_verdict;
  end
endmodule
`default_nettype wire
